/* inc/irpr_cfg.svh */
// Constants for the register pair read block of the I/O expander.
// Overview of operation
// - After repeated START with R/W 1, device returns the selected register.
// - Each further byte read comes from the other register of the pair.
// - After a later restart the pointer holds the partner of the last read.
// - Port data is captured into the read register at the ACK clock rise.
// - Each pin has its own two-bit drive setting selecting one of three levels; 01b and 10b both give two fingers.
// - Drive setting 10b enables only two driver fingers, half drive.
// - Synchronous reset, while high, puts all registers and the bus state machine at defaults.
// - Reading a port clears its pending interrupt at the ACK/NACK rising SCL.
`ifndef IRPR_CFG_SVH
`define IRPR_CFG_SVH
`define IRPR_DEV_ADDR 7'h20
`define IRPR_PTR_RESET 8'h00
`define IRPR_REG_IN0 8'h00
`define IRPR_REG_IN1 8'h01
`define IRPR_REG_DRV_BASE 8'h40
`define IRPR_FINGERS 4
`define IRPR_DRV_RESET 32'hFFFFFFFF
`endif

/* inc/irpr_pkg.sv */
// Types shared by the register pair read block.
package irpr_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_CMD,
        ST_WDATA,
        ST_RDATA,
        ST_RACK
    } irpr_state_t;
    typedef struct packed {
        logic in;
        logic out;
        logic oe;
    } irpr_pin_t;
endpackage

/* testbench/irpr_master.sv */
// Bit-level I2C bus master model that paces SCL from the system clock.
`timescale 1ns/100ps
`default_nettype none
module irpr_master (
    input wire logic ref_clk, // Pacing clock.
    input wire logic sda_line, // Resolved SDA level.
    output logic scl, // SCL, high and still between frames.
    output logic sda_rel // High while SDA is released to the pull-up.
);
    int phase = 8;
    // Both lines are released while the bus idles.
    initial begin
        scl = 1'h1;
        sda_rel = 1'h1;
    end
    // Every change lands just after an edge, one phase apart; phase sets fast or slow pacing.
    task automatic tick();
        repeat (phase) @(posedge ref_clk);
        #1;
    endtask
    // SDA moves one phase after SCL falls, so no edge of the two lines ever coincides.
    task automatic send_bit(input logic b, output logic seen);
        tick();
        sda_rel = b;
        tick();
        scl = 1'h1;
        tick();
        seen = sda_line;
        scl = 1'h0;
    endtask
    // Start and repeated start alike: SDA falls while SCL is high.
    task automatic start();
        tick();
        sda_rel = 1'h1;
        tick();
        scl = 1'h1;
        tick();
        sda_rel = 1'h0;
        tick();
        scl = 1'h0;
    endtask
    // Stop leaves the bus released.
    task automatic stop();
        tick();
        sda_rel = 1'h0;
        tick();
        scl = 1'h1;
        tick();
        sda_rel = 1'h1;
        tick();
    endtask
    // Address and command bytes go out this way; the ninth bit reads the acknowledge.
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            send_bit(b[i], s);
        end
        send_bit(1'h1, s);
        ack = ~s;
    endtask
    // The last wanted byte is answered with a not-acknowledge.
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            send_bit(1'h1, s);
            d[i] = s;
        end
        send_bit(last, s);
    endtask
endmodule
`default_nettype wire

/* testbench/tb_i2c_register_pair_read.sv */
// Self-checking bench for the register pair read block.
`timescale 1ns/100ps
`default_nettype none
`include "irpr_cfg.svh"
module tb_i2c_register_pair_read;
    logic ref_clk = 1'h0;
    logic reset, sda_oe, scl, sda_rel, ack;
    logic [15:0] port_in, int_pending, int_clear;
    logic [31:0] drive_setting;
    logic [63:0] finger_en;
    logic [7:0] pointer, d;
    logic [15:0] clr_seen;
    logic [95:0] rows [5];
    wire logic sda_line;
    int bad_count = 0;
    int comparisons = 0;
    // Open-drain SDA: the pull-up wins unless a party pulls low.
    assign sda_line = sda_rel & ~sda_oe;
    always #5 ref_clk = ~ref_clk;
    // Clear pulses last one cycle, so they are gathered rather than sampled late.
    always @(posedge ref_clk) clr_seen <= reset ? 16'h0 : (clr_seen | int_clear);
    irpr_master master (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_rel(sda_rel));
    irpr_top #(.PINS(16)) dut (.ref_clk(ref_clk), .reset(reset), .scl_in(scl), .sda_in(sda_line),
        .sda_oe(sda_oe), .port_in(port_in), .drive_setting(drive_setting), .int_pending(int_pending),
        .int_clear(int_clear), .finger_en(finger_en), .pointer(pointer));
    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Address the device, select a register, restart for reading.
    task automatic access(input logic [7:0] cmd);
        master.start();
        master.wbyte({`IRPR_DEV_ADDR, 1'h0}, ack);
        check("write address ack", 64'h1, {63'h0, ack});
        master.wbyte(cmd, ack);
        check("command pointer", {56'h0, cmd}, {56'h0, pointer});
        master.start();
        master.wbyte({`IRPR_DEV_ADDR, 1'h1}, ack);
        check("read address ack", 64'h1, {63'h0, ack});
    endtask
    // Every byte, the first too, carries the port half of the register it was read from.
    task automatic read_run(input logic [7:0] first, input int n);
        logic [7:0] reg_sel;
        for (int k = 0; k < n; k++) begin
            reg_sel = first ^ 8'(k % 2);
            master.rbyte(k == n - 1, d);
            check("read data", {56'h0, reg_sel[0] ? port_in[15:8] : port_in[7:0]}, {56'h0, d});
            check("pointer", {56'h0, first ^ 8'((k + 1) % 2)}, {56'h0, pointer});
        end
    endtask
    // A hang anywhere is cut short here.
    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        results();
    end
    initial begin
        reset = 1'h1;
        port_in = 16'h3CA5;
        int_pending = 16'hFFFF;
        drive_setting = {16{2'h2}};
        rows[0] = {{16{2'h0}}, {16{4'h1}}};
        rows[1] = {{16{2'h1}}, {16{4'h3}}};
        rows[2] = {{16{2'h2}}, {16{4'h3}}};
        rows[3] = {{16{2'h3}}, {16{4'hF}}};
        rows[4] = {{15{2'h3}}, 2'h2, {15{4'hF}}, 4'h3};
        repeat (3) @(posedge ref_clk);
        #1;
        check("reset pointer", 64'h0, {56'h0, pointer});
        check("reset sda", 64'h0, {63'h0, sda_oe});
        check("reset fingers", {16{4'hF}}, finger_en);
        reset = 1'h0;
        // Each row sets the drive codes and the finger pattern they should give.
        for (int r = 0; r < 5; r++) begin
            drive_setting = rows[r][95:64];
            repeat (2) @(posedge ref_clk);
            #1;
            check("finger enables", rows[r][63:0], finger_en);
        end
        // Three bytes from register 1, then a restart without a new command.
        access(8'h01);
        read_run(8'h01, 3);
        master.start();
        master.wbyte({`IRPR_DEV_ADDR, 1'h1}, ack);
        check("restart address ack", 64'h1, {63'h0, ack});
        check("pointer after restart", 64'h0, {56'h0, pointer});
        read_run(8'h00, 2);
        master.stop();
        check("interrupt clears", 64'hFFFF, {48'h0, clr_seen});
        // A foreign address and its command byte are ignored; the pointer keeps the partner of the last read.
        master.start();
        master.wbyte({`IRPR_DEV_ADDR ^ 7'h01, 1'h0}, ack);
        check("foreign address ack", 64'h0, {63'h0, ack});
        master.wbyte(8'h03, ack);
        check("foreign command ack", 64'h0, {63'h0, ack});
        master.stop();
        check("pointer kept", 64'h0, {56'h0, pointer});
        // Reset in mid-transfer returns everything to defaults.
        master.start();
        master.wbyte({`IRPR_DEV_ADDR, 1'h0}, ack);
        master.wbyte(8'h03, ack);
        reset = 1'h1;
        repeat (3) @(posedge ref_clk);
        #1;
        check("mid reset pointer", 64'h0, {56'h0, pointer});
        check("mid reset sda", 64'h0, {63'h0, sda_oe});
        reset = 1'h0;
        repeat (3) @(posedge ref_clk);
        #1;
        master.stop();
        // Faster pacing, pointer 3 pairs with 2.
        master.phase = 5;
        access(8'h03);
        read_run(8'h03, 2);
        master.stop();
        results();
    end
endmodule
`default_nettype wire

/* verilog/irpr_drive.sv */
// Per-pin drive strength decoder that turns a two-bit setting into finger enables.
`timescale 1ns/100ps
`default_nettype none
`include "irpr_cfg.svh"
module irpr_drive #(
    parameter int PINS = 16
) (
    input wire logic ref_clk, // System clock.
    input wire logic reset, // Synchronous reset, active high.
    input wire logic [2*PINS-1:0] drive_setting, // Two bits per pin.
    output logic [`IRPR_FINGERS*PINS-1:0] finger_en // Registered finger enables.
);
    // Setting counts enabled fingers: 00 one, 01 two... except 10 gives two, 11 all four.
    function automatic logic [3:0] fingers(input logic [1:0] s);
        case (s)
            2'h0: fingers = 4'h1;
            2'h1: fingers = 4'h3;
            2'h2: fingers = 4'h3;
            default: fingers = 4'hF;
        endcase
    endfunction
    // Each pin decodes independently so settings never interact.
    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_pin
            wire [3:0] dec_next = fingers(drive_setting[2*g+1:2*g]);
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    finger_en[4*g+3:4*g] <= 4'hF;
                end else begin
                    finger_en[4*g+3:4*g] <= dec_next;
                end
            end
            a_half_drive: assert property (@(posedge ref_clk) disable iff (reset)
                drive_setting[2*g+1:2*g] == 2'h2 |=> finger_en[4*g+3:4*g] == 4'h3)
                else $error("half drive setting did not give two fingers");
        end
    endgenerate
endmodule
`default_nettype wire

/* verilog/irpr_top.sv */
// I2C slave read path with register pair alternation and drive strength outputs.
`timescale 1ns/100ps
`default_nettype none
`include "irpr_cfg.svh"
module irpr_top #(
    parameter int PINS = 16
) (
    input wire logic ref_clk, // System clock, 100 MHz.
    input wire logic reset, // Synchronous reset, active high.
    input wire logic scl_in, // SCL pin level.
    input wire logic sda_in, // SDA pin level.
    output logic sda_oe, // High while pulling SDA low.
    input wire logic [PINS-1:0] port_in, // Port pin levels.
    input wire logic [2*PINS-1:0] drive_setting, // Drive strength per pin.
    input wire logic [PINS-1:0] int_pending, // Pending port change flags.
    output logic [PINS-1:0] int_clear, // One-cycle clear of pending flags.
    output logic [`IRPR_FINGERS*PINS-1:0] finger_en, // Driver finger enables.
    output logic [7:0] pointer // Current register pointer.
);
    // Two-stage synchronisers for the bus pins.
    logic scl_s1_reg, scl_s2_reg, scl_d_reg, sda_s1_reg, sda_s2_reg, sda_d_reg;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            {scl_s1_reg, scl_s2_reg, scl_d_reg} <= 3'h7;
            {sda_s1_reg, sda_s2_reg, sda_d_reg} <= 3'h7;
        end else begin
            {scl_s1_reg, scl_s2_reg, scl_d_reg} <= {scl_in, scl_s1_reg, scl_s2_reg};
            {sda_s1_reg, sda_s2_reg, sda_d_reg} <= {sda_in, sda_s1_reg, sda_s2_reg};
        end
    end
    // Bus events decoded from the synchronised levels.
    wire scl_rise = scl_s2_reg & ~scl_d_reg;
    wire scl_fall = ~scl_s2_reg & scl_d_reg;
    wire start_det = scl_s2_reg & scl_d_reg & ~sda_s2_reg & sda_d_reg;
    wire stop_det = scl_s2_reg & scl_d_reg & sda_s2_reg & ~sda_d_reg;

    irpr_pkg::irpr_state_t state_reg, state_next;
    logic [7:0] shift_reg, shift_next, ptr_reg, ptr_next;
    logic [3:0] bit_reg, bit_next;
    logic rw_reg, rw_next, sda_oe_reg, sda_oe_next, cap_reg, cap_next;
    logic [PINS-1:0] clr_reg, clr_next;
    logic [7:0] port_half;

    // Partner of a pair differs only in the lowest pointer bit.
    function automatic logic [7:0] partner(input logic [7:0] p);
        partner = {p[7:1], ~p[0]};
    endfunction

    // Port data for the register selected; port 1 is the upper half of the pins.
    assign port_half = ptr_reg[0] ? port_in[PINS-1:8] : port_in[7:0];
    // Clear mask for the half just read; only flags that are really pending get a pulse.
    wire [PINS-1:0] read_half_mask = ptr_reg[0] ? {{(PINS-8){1'b1}}, 8'h00} : {{(PINS-8){1'b0}}, 8'hFF};
    wire ack_phase = (bit_reg == 4'h8);

    // Main bus state machine; events are checked in priority order start, stop, clock.
    always_comb begin
        state_next = state_reg;
        shift_next = shift_reg;
        ptr_next = ptr_reg;
        bit_next = bit_reg;
        rw_next = rw_reg;
        sda_oe_next = sda_oe_reg;
        cap_next = 1'b0;
        clr_next = '0;
        if (start_det) begin
            state_next = irpr_pkg::ST_ADDR;
            // The SCL fall that closes the START is no data bit, so it wraps the counter to zero.
            bit_next = 4'hF;
            sda_oe_next = 1'b0;
        end else if (stop_det) begin
            state_next = irpr_pkg::ST_IDLE;
            sda_oe_next = 1'b0;
        end else begin
            case (state_reg)
                irpr_pkg::ST_ADDR, irpr_pkg::ST_CMD, irpr_pkg::ST_WDATA: begin
                    if (scl_rise && !ack_phase) begin
                        shift_next = {shift_reg[6:0], sda_s2_reg};
                    end
                    // A read opens with a capture at the address ACK rise, so its first byte is register data.
                    if (scl_rise && ack_phase && state_reg == irpr_pkg::ST_ADDR && rw_reg) begin
                        cap_next = 1'b1;
                    end
                    if (scl_fall) begin
                        bit_next = bit_reg + 4'h1;
                        if (bit_reg == 4'h7) begin
                            if (state_reg == irpr_pkg::ST_ADDR) begin
                                sda_oe_next = (shift_reg[7:1] == `IRPR_DEV_ADDR);
                                rw_next = shift_reg[0];
                                if (shift_reg[7:1] != `IRPR_DEV_ADDR) begin
                                    state_next = irpr_pkg::ST_IDLE;
                                end
                            end else begin
                                sda_oe_next = 1'b1;
                                if (state_reg == irpr_pkg::ST_CMD) begin
                                    ptr_next = shift_reg;
                                end
                            end
                        end else if (ack_phase) begin
                            bit_next = 4'h0;
                            sda_oe_next = 1'b0;
                            if (state_reg == irpr_pkg::ST_ADDR && rw_reg) begin
                                state_next = irpr_pkg::ST_RDATA;
                                bit_next = 4'h0;
                                sda_oe_next = ~shift_reg[7];
                                shift_next = {shift_reg[6:0], 1'b1};
                            end else if (state_reg == irpr_pkg::ST_ADDR) begin
                                state_next = irpr_pkg::ST_CMD;
                            end else begin
                                state_next = irpr_pkg::ST_WDATA;
                            end
                        end
                    end
                end
                irpr_pkg::ST_RDATA: begin
                    if (scl_fall) begin
                        bit_next = bit_reg + 4'h1;
                        if (bit_reg == 4'h7) begin
                            sda_oe_next = 1'b0;
                            state_next = irpr_pkg::ST_RACK;
                        end else begin
                            sda_oe_next = ~shift_reg[7];
                            shift_next = {shift_reg[6:0], 1'b1};
                        end
                    end
                end
                irpr_pkg::ST_RACK: begin
                    if (scl_rise) begin
                        cap_next = 1'b1;
                        ptr_next = partner(ptr_reg);
                        if (ptr_reg == `IRPR_REG_IN0 || ptr_reg == `IRPR_REG_IN1) begin
                            clr_next = read_half_mask & int_pending;
                        end
                        if (sda_s2_reg) begin
                            state_next = irpr_pkg::ST_IDLE;
                        end
                    end
                    if (scl_fall && state_reg == irpr_pkg::ST_RACK) begin
                        state_next = irpr_pkg::ST_RDATA;
                        bit_next = 4'h0;
                        sda_oe_next = ~shift_reg[7];
                        shift_next = {shift_reg[6:0], 1'b1};
                    end
                end
                default: begin
                    state_next = irpr_pkg::ST_IDLE;
                end
            endcase
        end
        // The captured byte replaces the shifter so the next byte carries fresh port data.
        if (cap_reg) begin
            shift_next = port_half;
        end
    end

    // All bus state returns to defaults on reset.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_reg <= irpr_pkg::ST_IDLE;
            shift_reg <= 8'h00;
            ptr_reg <= `IRPR_PTR_RESET;
            bit_reg <= 4'h0;
            rw_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            cap_reg <= 1'b0;
            clr_reg <= '0;
        end else begin
            state_reg <= state_next;
            shift_reg <= shift_next;
            ptr_reg <= ptr_next;
            bit_reg <= bit_next;
            rw_reg <= rw_next;
            sda_oe_reg <= sda_oe_next;
            cap_reg <= cap_next;
            clr_reg <= clr_next;
        end
    end

    // The first data byte is loaded at the address ACK rise, before the read phase begins.
    assign sda_oe = sda_oe_reg;
    assign int_clear = clr_reg;
    assign pointer = ptr_reg;

    irpr_drive #(.PINS(PINS)) u_drive (
        .ref_clk(ref_clk),
        .reset(reset),
        .drive_setting(drive_setting),
        .finger_en(finger_en)
    );

    sequence s_ack_rise;
        state_reg == irpr_pkg::ST_RACK && scl_rise && !start_det && !stop_det;
    endsequence
    a_pair_alternate: assert property (@(posedge ref_clk) disable iff (reset)
        s_ack_rise |=> ptr_reg == {$past(ptr_reg[7:1]), ~$past(ptr_reg[0])})
        else $error("pointer did not move to partner register");
    a_capture_ack: assert property (@(posedge ref_clk) disable iff (reset)
        s_ack_rise |=> cap_reg)
        else $error("port data not captured at ack rise");
    a_nack_ends: assert property (@(posedge ref_clk) disable iff (reset)
        s_ack_rise and sda_s2_reg |=> state_reg == irpr_pkg::ST_IDLE)
        else $error("nack did not end read");
    a_ptr_hold: assert property (@(posedge ref_clk) disable iff (reset)
        start_det |=> ptr_reg == $past(ptr_reg))
        else $error("pointer changed on restart");
    a_clear_one: assert property (@(posedge ref_clk) disable iff (reset)
        int_clear != '0 |=> int_clear == '0)
        else $error("interrupt clear longer than one cycle");
    a_reset_idle: assert property (@(posedge ref_clk)
        reset |=> state_reg == irpr_pkg::ST_IDLE && !sda_oe && ptr_reg == `IRPR_PTR_RESET)
        else $error("reset did not restore defaults");
    a_cmd_load: assert property (@(posedge ref_clk) disable iff (reset)
        state_reg == irpr_pkg::ST_CMD && scl_fall && bit_reg == 4'h7 && !start_det && !stop_det
        |=> ptr_reg == $past(shift_reg))
        else $error("command byte not loaded into pointer");
endmodule
`default_nettype wire
